/* File: design/aocb_pkg.sv */
/*
  Constants for the offset and mode configuration bank: register indices,
  field positions, reset values and datapath timing.
  Assumes it is compiled before any module that imports it.
*/
package aocb_pkg;
  // ------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_PERF_TUNE_A = 8'h02;
  localparam logic [7:0] IDX_CHAN_A_BIAS = 8'hBF;
  localparam logic [7:0] IDX_CHAN_B_BIAS = 8'hC1;
  localparam logic [7:0] IDX_DC_LOOP_CTRL = 8'hCF;
  localparam logic [7:0] IDX_PERF_TUNE_B = 8'hD5;
  localparam logic [7:0] IDX_PERF_TUNE_C = 8'hD7;
  localparam logic [7:0] IDX_PERF_TUNE_D = 8'hDB;
  localparam logic [7:0] IDX_SLOW_GATE = 8'hEF;
  localparam logic [7:0] IDX_AMP_GATE = 8'hF1;
  localparam logic [7:0] IDX_SLOW_CHAN_A = 8'hF2;
  localparam logic [7:0] IDX_LOOP_ENABLE = 8'h3D;
  localparam logic [7:0] IDX_DIGITAL_CTRL = 8'h42;
  localparam logic [7:0] IDX_STATUS = 8'hFC;
  // ------------------------------------------------------------
  // Writable bit masks, everything else reserved and read as zero
  // ------------------------------------------------------------
  localparam logic [7:0] MASK_PERF_TUNE_A = 8'h40;
  localparam logic [7:0] MASK_BIAS = 8'hFC;
  localparam logic [7:0] MASK_DC_LOOP_CTRL = 8'hBC;
  localparam logic [7:0] MASK_PERF_TUNE_B = 8'h18;
  localparam logic [7:0] MASK_PERF_TUNE_C = 8'h0C;
  localparam logic [7:0] MASK_PERF_TUNE_D = 8'h21;
  localparam logic [7:0] MASK_SLOW_GATE = 8'h10;
  localparam logic [7:0] MASK_AMP_GATE = 8'h03;
  localparam logic [7:0] MASK_SLOW_CHAN_A = 8'h08;
  localparam logic [7:0] MASK_LOOP_ENABLE = 8'h20;
  localparam logic [7:0] MASK_DIGITAL_CTRL = 8'h08;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIAS_LSB = 2;
  localparam int BIAS_MSB = 7;
  localparam int HOLD_BIT = 7;
  localparam int AVG_LSB = 2;
  localparam int AVG_MSB = 5;
  localparam int SLOW_GATE_BIT = 4;
  localparam int SLOW_A_BIT = 3;
  localparam int SLOW_B_BIT = 0;
  localparam int LOOP_EN_BIT = 5;
  localparam int DIGITAL_EN_BIT = 3;
  localparam int TUNE3_BIT = 6;
  localparam int TUNE4_BIT = 4;
  localparam int TUNE5_BIT = 3;
  localparam int TUNE6_BIT = 3;
  localparam int TUNE7_BIT = 2;
  localparam int TUNE8_BIT = 5;
  localparam logic [1:0] AMP_GATE_OFF = 2'h0;
  localparam logic [1:0] AMP_GATE_ON = 2'h3;
  // ------------------------------------------------------------
  // Datapath timing
  // ------------------------------------------------------------
  localparam int SAMPLE_LATENCY = 16;
  localparam int SAMPLE_WIDTH = 14;
  localparam int AVG_BASE_SHIFT = 4;
  localparam logic [SAMPLE_WIDTH-1:0] MIDCODE = 14'h2000;
endpackage

/* File: design/aocb_delay_line.sv */
/*
  Fixed-length pipeline delay for a pair of channel words.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module aocb_delay_line
  import aocb_pkg::*;
#(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Data in and out
  input wire logic [WIDTH-1:0] dinA,
  input wire logic [WIDTH-1:0] dinB,
  output logic [WIDTH-1:0] doutA,
  output logic [WIDTH-1:0] doutB
);
  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (DEPTH < 1) begin : gBadDepth
    $error("Delay depth must be at least one");
  end

  logic [WIDTH-1:0] stageA_ff [DEPTH];
  logic [WIDTH-1:0] stageB_ff [DEPTH];

  // Each stage is a plain register; one edge per stage
  for (genvar i = 0; i < DEPTH; i++) begin : gStage
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        stageA_ff[i] <= '0;
        stageB_ff[i] <= '0;
      end else begin
        stageA_ff[i] <= (i == 0) ? dinA : stageA_ff[(i == 0) ? 0 : i-1];
        stageB_ff[i] <= (i == 0) ? dinB : stageB_ff[(i == 0) ? 0 : i-1];
      end
    end
  end

  assign doutA = stageA_ff[DEPTH-1];
  assign doutB = stageB_ff[DEPTH-1];
endmodule

/* File: design/aocb_config_bank.sv */
/*
  Configuration bank for a dual-channel converter: APB register slave, the
  offset loop with hold and averaging, midcode bias, gated slow-rate modes,
  amplitude gate, tuning bits and the fixed-latency output path.
  Assumes samples arrive on mclk from logic in the same domain and an APB
  master on the same clock.
*/
`timescale 1ns/100ps
// How it works
// - Signed six-bit bias shifts output around midcode, only while the loop is enabled
// - Enabled loop converges output to midcode plus bias
// - Separate bias register per channel, own address
// - Hold freezes estimate, last value still applied
// - Bits 5..2 set loop averaging period
// - Gate zero disables slow-rate on both channels
// - Bit 3 enables channel A slow-rate, gated
// - Bit 0 enables channel B slow-rate, gated
// - Amplitude gate on only for 11, off otherwise
// - Both channels sampled on same rising edge
// - Sample appears exactly 16 cycles later
// - Output as offset binary or two's complement
// - Loop enable bit 5 turns loop on
// - Global digital enable gates the offset loop and bias only
module aocb_config_bank
  import aocb_pkg::*;
#(
  parameter int LATENCY = SAMPLE_LATENCY
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample path
  input wire logic [SAMPLE_WIDTH-1:0] rawA,
  input wire logic [SAMPLE_WIDTH-1:0] rawB,
  input wire logic twosComplement,
  output logic [SAMPLE_WIDTH-1:0] codeA,
  output logic [SAMPLE_WIDTH-1:0] codeB,
  // Mode outputs
  output logic chanASlowRate,
  output logic chanBSlowRate,
  output logic amplitudeCtrlEnable,
  output logic performanceTuneAll
);
  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (LATENCY < 3) begin : gBadLatency
    $error("Latency must leave room for the two processing stages");
  end

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  localparam int NREG = 12;
  localparam logic [7:0] REG_IDX [NREG] = '{IDX_PERF_TUNE_A, IDX_CHAN_A_BIAS, IDX_CHAN_B_BIAS,
    IDX_DC_LOOP_CTRL, IDX_PERF_TUNE_B, IDX_PERF_TUNE_C, IDX_PERF_TUNE_D, IDX_SLOW_GATE,
    IDX_AMP_GATE, IDX_SLOW_CHAN_A, IDX_LOOP_ENABLE, IDX_DIGITAL_CTRL};
  localparam logic [7:0] REG_MASK [NREG] = '{MASK_PERF_TUNE_A, MASK_BIAS, MASK_BIAS,
    MASK_DC_LOOP_CTRL, MASK_PERF_TUNE_B, MASK_PERF_TUNE_C, MASK_PERF_TUNE_D, MASK_SLOW_GATE,
    MASK_AMP_GATE, MASK_SLOW_CHAN_A, MASK_LOOP_ENABLE, MASK_DIGITAL_CTRL};

  logic [7:0] regs_ff [NREG];
  logic [NREG-1:0] hit;
  logic anyHit;
  logic statusHit;
  logic wordAligned;
  logic access;
  logic writeLow;
  logic [7:0] readByte;
  logic [7:0] statusByte;

  // Byte address is four times the printed index
  assign wordAligned = (paddr[1:0] == 2'h0);
  assign access = psel & penable;
  assign writeLow = access & pwrite & pstrb[0];
  assign statusHit = wordAligned & (paddr[9:2] == IDX_STATUS);
  assign anyHit = |hit;

  // Decode each register once; a loop keeps entries in one table
  for (genvar r = 0; r < NREG; r++) begin : gReg
    assign hit[r] = wordAligned & (paddr[9:2] == REG_IDX[r]);
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        regs_ff[r] <= REG_RESET;
      end else if (writeLow && hit[r]) begin
        regs_ff[r] <= pwdata[7:0] & REG_MASK[r];
      end
    end
  end

  // Read mux, reserved bits are masked off at write time
  always_comb begin
    readByte = 8'h00;
    for (int r = 0; r < NREG; r++) begin
      if (hit[r]) begin
        readByte = regs_ff[r];
      end
    end
    if (statusHit) begin
      readByte = statusByte;
    end
  end

  // Zero-wait slave; unmapped or misaligned addresses raise pslverr
  assign pready = 1'b1;
  assign pslverr = access & ~(anyHit | (statusHit & ~pwrite));
  assign prdata = (access & ~pwrite) ? {24'h000000, readByte} : 32'h00000000;

  // ------------------------------------------------------------
  // Field extraction
  // ------------------------------------------------------------
  logic digitalEnable;
  logic loopEnable;
  logic loopHold;
  logic [3:0] avgField;
  logic signed [5:0] biasA;
  logic signed [5:0] biasB;
  logic slowGate;
  logic [1:0] ampGate;

  assign digitalEnable = regs_ff[11][DIGITAL_EN_BIT];
  assign loopEnable = regs_ff[10][LOOP_EN_BIT] & digitalEnable;
  assign loopHold = regs_ff[3][HOLD_BIT];
  assign avgField = regs_ff[3][AVG_MSB:AVG_LSB];
  assign biasA = signed'(regs_ff[1][BIAS_MSB:BIAS_LSB]);
  assign biasB = signed'(regs_ff[2][BIAS_MSB:BIAS_LSB]);
  assign slowGate = regs_ff[7][SLOW_GATE_BIT];
  assign ampGate = regs_ff[8][1:0];

  // Slow-rate bits count only through the gate
  assign chanASlowRate = slowGate & regs_ff[9][SLOW_A_BIT];
  assign chanBSlowRate = slowGate & regs_ff[6][SLOW_B_BIT];
  // Illegal codes 01 and 10 are treated as off to fail safe
  assign amplitudeCtrlEnable = (ampGate == AMP_GATE_ON);
  assign performanceTuneAll = regs_ff[0][TUNE3_BIT] & regs_ff[4][TUNE4_BIT] & regs_ff[4][TUNE5_BIT]
    & regs_ff[5][TUNE6_BIT] & regs_ff[5][TUNE7_BIT] & regs_ff[6][TUNE8_BIT];
  assign statusByte = {3'h0, loopEnable & loopHold, loopEnable, performanceTuneAll,
    chanBSlowRate, chanASlowRate};

  // ------------------------------------------------------------
  // Offset loop: one sample register stage and one correction stage
  // ------------------------------------------------------------
  localparam int ACC_W = SAMPLE_WIDTH + 20;
  logic signed [SAMPLE_WIDTH:0] capA_ff, capB_ff;
  logic signed [ACC_W-1:0] accA_ff, accB_ff;
  logic signed [ACC_W-1:0] nxt_accA, nxt_accB;
  logic signed [SAMPLE_WIDTH:0] estA, estB;
  logic [4:0] shiftAmt;
  logic [SAMPLE_WIDTH-1:0] corrA_ff, corrB_ff;
  logic [SAMPLE_WIDTH-1:0] nxt_corrA, nxt_corrB;

  // Larger field gives a longer period: 2^(field+4) samples
  assign shiftAmt = 5'(avgField) + 5'(AVG_BASE_SHIFT);

  // Both channels are captured on the same edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      capA_ff <= '0;
      capB_ff <= '0;
    end else begin
      capA_ff <= signed'({1'b0, rawA}) - signed'({1'b0, MIDCODE});
      capB_ff <= signed'({1'b0, rawB}) - signed'({1'b0, MIDCODE});
    end
  end

  // Estimates are the accumulators scaled by the averaging period
  assign estA = (SAMPLE_WIDTH+1)'(accA_ff >>> shiftAmt);
  assign estB = (SAMPLE_WIDTH+1)'(accB_ff >>> shiftAmt);

  // Leaky average; held value stays in place while frozen
  always_comb begin
    nxt_accA = accA_ff;
    nxt_accB = accB_ff;
    if (!loopEnable) begin
      nxt_accA = '0;
      nxt_accB = '0;
    end else if (!loopHold) begin
      nxt_accA = accA_ff + ACC_W'(capA_ff) - ACC_W'(estA);
      nxt_accB = accB_ff + ACC_W'(capB_ff) - ACC_W'(estB);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      accA_ff <= '0;
      accB_ff <= '0;
    end else begin
      accA_ff <= nxt_accA;
      accB_ff <= nxt_accB;
    end
  end

  // Correct, add bias, saturate and format; keeps the code in range
  function automatic logic [SAMPLE_WIDTH-1:0] correctCode(input logic signed [SAMPLE_WIDTH:0] cap,
    input logic signed [SAMPLE_WIDTH:0] est, input logic signed [5:0] bias, input logic en,
    input logic twos);
    logic signed [SAMPLE_WIDTH+1:0] sum;
    logic [SAMPLE_WIDTH-1:0] obin;
    sum = (SAMPLE_WIDTH+2)'(cap);
    if (en) begin
      sum = sum - (SAMPLE_WIDTH+2)'(est) + (SAMPLE_WIDTH+2)'(bias);
    end
    if (sum > (SAMPLE_WIDTH+2)'(8191)) begin
      sum = (SAMPLE_WIDTH+2)'(8191);
    end else if (sum < -(SAMPLE_WIDTH+2)'(8192)) begin
      sum = -(SAMPLE_WIDTH+2)'(8192);
    end
    obin = sum[SAMPLE_WIDTH-1:0] ^ MIDCODE;
    return twos ? sum[SAMPLE_WIDTH-1:0] : obin;
  endfunction

  assign nxt_corrA = correctCode(capA_ff, estA, biasA, loopEnable, twosComplement);
  assign nxt_corrB = correctCode(capB_ff, estB, biasB, loopEnable, twosComplement);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      corrA_ff <= '0;
      corrB_ff <= '0;
    end else begin
      corrA_ff <= nxt_corrA;
      corrB_ff <= nxt_corrB;
    end
  end

  // ------------------------------------------------------------
  // Remaining latency; the capture edge starts the count, so only
  // the correction stage is taken off the delay line
  // ------------------------------------------------------------
  aocb_delay_line #(
    .WIDTH(SAMPLE_WIDTH),
    .DEPTH(LATENCY - 1)
  ) uDelay (
    .mclk(mclk),
    .reset(reset),
    .dinA(corrA_ff),
    .dinB(corrB_ff),
    .doutA(codeA),
    .doutB(codeB)
  );
endmodule

/* File: verification/aocb_checker_properties.sv */
/*
  Port-level checker for the configuration bank: APB answer and mode outputs.
  Assumes it is bound into the bank and sees its ports by name.
*/
`timescale 1ns/100ps
module aocb_checker
  import aocb_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Mode outputs
  input wire logic chanASlowRate,
  input wire logic chanBSlowRate,
  input wire logic amplitudeCtrlEnable,
  input wire logic performanceTuneAll
);
  // ----------------------------------------
  // Access decode and properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Writes only count with the low lane strobe, as the bank takes them
  wire acc = psel && penable;
  wire wrOk = acc && pwrite && pstrb[0];
  a_ready_high: assert property (pready) else $error("pready low");
  a_idle_rdata: assert property (!acc |-> prdata == 32'h0) else $error("read data outside access");
  a_rdata_lane: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper lanes set");
  a_misalign_err: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned accepted");
  a_bias_low: assert property (acc && !pwrite && paddr == {IDX_CHAN_B_BIAS, 2'h0} |-> prdata[1:0] == 2'h0)
    else $error("bias low bits set");
  a_gate_off: assert property (wrOk && paddr == {IDX_SLOW_GATE, 2'h0} && !pwdata[SLOW_GATE_BIT]
    |=> !chanASlowRate && !chanBSlowRate) else $error("slow rate without gate");
  a_slow_a_off: assert property (wrOk && paddr == {IDX_SLOW_CHAN_A, 2'h0} && !pwdata[SLOW_A_BIT]
    |=> !chanASlowRate) else $error("channel A slow rate stuck");
  a_amp_code: assert property (wrOk && paddr == {IDX_AMP_GATE, 2'h0}
    |=> amplitudeCtrlEnable == ($past(pwdata[1:0]) == AMP_GATE_ON)) else $error("amplitude gate wrong");
  a_tune_clear: assert property (wrOk && paddr == {IDX_PERF_TUNE_A, 2'h0} && !pwdata[TUNE3_BIT]
    |=> !performanceTuneAll) else $error("tune flag with bit clear");
  a_reset_zero: assert property ($fell(reset) |-> !chanASlowRate && !chanBSlowRate
    && !amplitudeCtrlEnable && !performanceTuneAll) else $error("mode set after reset");
endmodule

/* File: verification/aocb_apb_master.sv */
/*
  Configuration master model: drives APB transfers for the bench.
  Assumes the bench top is named testbench and owns test_done.
*/
`timescale 1ns/100ps
module aocb_apb_master (
  // Clock
  input wire logic mclk,
  // Request
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [9:0] paddr = 10'h000,
  output logic [31:0] pwdata = 32'h0,
  output logic [3:0] pstrb = 4'h1,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // One transfer; request held until pready is seen, bounded so a hang ends the run
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      $display("wrong value at %0t: no pready", $time);
      testbench.num_errors++;
      testbench.test_done();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule

/* File: verification/testbench.sv */
/*
  Self-checking bench for the configuration bank: registers, modes, latency, loop.
  Assumes the APB master model and the checker are compiled with it.
*/
`timescale 1ns/100ps
module testbench;
  import aocb_pkg::*;
  // ----------------------------------------
  // Signals, clock, reset
  // ----------------------------------------
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb;
  logic twosComplement = 1'b0;
  logic [13:0] rawA = 14'h0, rawB = 14'h0, codeA, codeB;
  logic chanASlowRate, chanBSlowRate, amplitudeCtrlEnable, performanceTuneAll;
  int num_errors = 0;
  int check_count = 0;
  localparam logic [7:0] regIdx [12] = '{IDX_PERF_TUNE_A, IDX_CHAN_A_BIAS, IDX_CHAN_B_BIAS, IDX_DC_LOOP_CTRL,
    IDX_PERF_TUNE_B, IDX_PERF_TUNE_C, IDX_PERF_TUNE_D, IDX_SLOW_GATE, IDX_AMP_GATE, IDX_SLOW_CHAN_A,
    IDX_LOOP_ENABLE, IDX_DIGITAL_CTRL};
  localparam logic [7:0] regMsk [12] = '{MASK_PERF_TUNE_A, MASK_BIAS, MASK_BIAS, MASK_DC_LOOP_CTRL,
    MASK_PERF_TUNE_B, MASK_PERF_TUNE_C, MASK_PERF_TUNE_D, MASK_SLOW_GATE, MASK_AMP_GATE, MASK_SLOW_CHAN_A,
    MASK_LOOP_ENABLE, MASK_DIGITAL_CTRL};
  initial forever #12.5 mclk = ~mclk;
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
  end
  aocb_config_bank dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .rawA, .rawB, .twosComplement, .codeA, .codeB, .chanASlowRate, .chanBSlowRate,
    .amplitudeCtrlEnable, .performanceTuneAll);
  aocb_apb_master m (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
  // ----------------------------------------
  // Bus helpers and compares
  // ----------------------------------------
  // Writes end at the falling edge so level outputs have settled
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    m.xfer(1'b1, {i, 2'h0}, d, r, e);
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] i);
    m.xfer(1'b0, {i, 2'h0}, 8'h00, r, e);
  endtask
  task automatic setRaw(input logic [13:0] a, input logic [13:0] b);
    @(posedge mclk);
    rawA <= a;
    rawB <= b;
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("wrong value at %0t: word %h, expected %h", $time, g, x);
    end
  endtask
  task automatic chkBit(input logic g, input logic x);
    chk32({31'h0, g}, {31'h0, x});
  endtask
  // Loop output settles near its target, so allow two codes either way
  task automatic chkNear(input logic [13:0] g, input logic [13:0] x);
    check_count++;
    if ((g - x + 14'd2) <= 14'd4) begin
    end else begin
      num_errors++;
      $display("wrong value at %0t: code %h, near %h", $time, g, x);
    end
  endtask
  task automatic test_done;
    $display("checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 12; i++) begin
      rd(regIdx[i]);
      chk32(r, 32'h0);
      wr(regIdx[i], 8'hFF);
      rd(regIdx[i]);
      chk32(r, {24'h0, regMsk[i]});
      wr(regIdx[i], 8'h00);
    end
    m.xfer(1'b0, 10'h000, 8'h00, r, e);
    chkBit(e, 1'b1);
    m.xfer(1'b0, {IDX_CHAN_B_BIAS, 2'h1}, 8'h00, r, e);
    chkBit(e, 1'b1);
    wr(IDX_STATUS, 8'hFF);
    chkBit(e, 1'b1);
  endtask
  task automatic t_slow;
    wr(IDX_SLOW_CHAN_A, 8'h08);
    wr(IDX_PERF_TUNE_D, 8'h01);
    chkBit(chanASlowRate, 1'b0);
    chkBit(chanBSlowRate, 1'b0);
    wr(IDX_SLOW_GATE, 8'h10);
    chkBit(chanASlowRate, 1'b1);
    chkBit(chanBSlowRate, 1'b1);
    rd(IDX_STATUS);
    chk32(r, 32'h00000003);
    wr(IDX_PERF_TUNE_D, 8'h00);
    chkBit(chanBSlowRate, 1'b0);
    wr(IDX_SLOW_GATE, 8'h00);
    wr(IDX_SLOW_CHAN_A, 8'h00);
  endtask
  // The two codes that must not be written are sent on purpose here
  task automatic t_amp;
    for (int v = 0; v < 4; v++) begin
      wr(IDX_AMP_GATE, 8'(v));
      chkBit(amplitudeCtrlEnable, v == 3);
    end
  endtask
  task automatic t_tune;
    wr(IDX_PERF_TUNE_A, 8'h40);
    wr(IDX_PERF_TUNE_B, 8'h18);
    wr(IDX_PERF_TUNE_C, 8'h0C);
    wr(IDX_PERF_TUNE_D, 8'h20);
    chkBit(performanceTuneAll, 1'b1);
    wr(IDX_PERF_TUNE_C, 8'h08);
    chkBit(performanceTuneAll, 1'b0);
  endtask
  task automatic t_lat(input logic t);
    logic [13:0] f;
    f = t ? MIDCODE : 14'h0;
    @(posedge mclk);
    twosComplement <= t;
    setRaw(14'h0ABC, 14'h0ABC);
    repeat (20) @(posedge mclk);
    setRaw(14'h1234, 14'h0321);
    setRaw(14'h0ABC, 14'h0ABC);
    repeat (15) @(posedge mclk);
    @(negedge mclk);
    chk32({18'h0, codeA}, {18'h0, 14'h0ABC ^ f});
    @(negedge mclk);
    chk32({18'h0, codeA}, {18'h0, 14'h1234 ^ f});
    chk32({18'h0, codeB}, {18'h0, 14'h0321 ^ f});
  endtask
  task automatic t_loop;
    setRaw(MIDCODE + 14'h50, MIDCODE + 14'h50);
    twosComplement <= 1'b0;
    wr(IDX_CHAN_A_BIAS, 8'h7C);
    wr(IDX_CHAN_B_BIAS, 8'h80);
    wr(IDX_DIGITAL_CTRL, 8'h08);
    wr(IDX_LOOP_ENABLE, 8'h20);
    repeat (1500) @(posedge mclk);
    @(negedge mclk);
    chkNear(codeA, MIDCODE + 14'h1F);
    chkNear(codeB, MIDCODE - 14'h20);
    wr(IDX_DC_LOOP_CTRL, 8'h80);
    setRaw(MIDCODE + 14'h78, MIDCODE + 14'h78);
    repeat (300) @(posedge mclk);
    @(negedge mclk);
    chkNear(codeA, MIDCODE + 14'h1F + 14'h28);
    wr(IDX_DIGITAL_CTRL, 8'h00);
    repeat (40) @(posedge mclk);
    @(negedge mclk);
    chkNear(codeA, MIDCODE + 14'h78);
    // Longest period: estimate must still be far from the input
    wr(IDX_DC_LOOP_CTRL, 8'h3C);
    wr(IDX_DIGITAL_CTRL, 8'h08);
    repeat (300) @(posedge mclk);
    @(negedge mclk);
    chkNear(codeA, MIDCODE + 14'h78 + 14'h1F);
  endtask
  initial begin
    @(negedge reset);
    t_regs;
    t_slow;
    t_amp;
    t_tune;
    t_lat(1'b0);
    t_lat(1'b1);
    t_loop;
    test_done;
  end
endmodule
bind aocb_config_bank aocb_checker chk (.*);
